// File: logic/lpm_pkg.sv
package lpm_pkg;

  // ----------------------------------------------------------------------
  // Interval and classification figures
  // ----------------------------------------------------------------------
  localparam int unsigned INTERVAL_MIN  = 15;
  localparam int unsigned INTERVAL_SECS = INTERVAL_MIN * 60;
  localparam int unsigned SES_LIMIT     = 300;
  localparam int unsigned UAS_RUN       = 10;
  localparam int unsigned HIST_DEPTH    = 96;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned TIMER_W = 10;
  localparam int unsigned EVT_W   = 16;
  localparam int unsigned CNT_W   = 10;
  localparam int unsigned BBE_W   = 24;
  localparam int unsigned DAY_W   = 17;
  localparam int unsigned DBBE_W  = 32;
  localparam int unsigned IDX_W   = 7;
  localparam int unsigned STAMP_W = 17;
  localparam int unsigned RUN_W   = 4;

  // ----------------------------------------------------------------------
  // Sized constants
  // ----------------------------------------------------------------------
  localparam logic [TIMER_W-1:0] TIMER_LAST  = TIMER_W'(INTERVAL_SECS - 1);
  localparam logic [EVT_W-1:0]   SES_LIM_V   = EVT_W'(SES_LIMIT);
  localparam logic [RUN_W-1:0]   UAS_RUN_V   = RUN_W'(UAS_RUN);
  localparam logic [IDX_W-1:0]   HIST_LAST   = IDX_W'(HIST_DEPTH - 1);
  localparam logic [IDX_W-1:0]   HIST_FULL   = IDX_W'(HIST_DEPTH);
  localparam logic [STAMP_W-1:0] DAY_SECS_M1 = STAMP_W'(86400 - 1);
  localparam logic [STAMP_W-1:0] STAMP_STEP  = STAMP_W'(INTERVAL_SECS);

  // CRC-4 polynomial x^4 + x + 1, low four bits
  localparam logic [3:0] CRC4_POLY = 4'h3;

endpackage

// File: logic/lpm_monitor.sv
`timescale 1ns/100ps
// Summary of operation
// R1 - Unavailable state true while unavailable counter runs
// R2 - Current counts cover a fifteen-minute interval
// R3 - Interval timer counts elapsed seconds
// R4 - Errored second: any frame or CRC error
// R5 - Severe second: 300+ CRC or alignment losses
// R6 - Unavailable counting starts after ten severe seconds
// R7 - Background errors counted outside severe seconds
// R8 - Keep 24-hour totals with same definitions
// R9 - Report valid intervals in last day
// R10 - Keep 96 interval records with start times
// R11 - Recompute CRC-4, count mismatching frames
// R12 - Interval end pushes history, clears, restarts
// R13 - Framer indications aligned to second strobe
module lpm_monitor (
  input  wire logic                          CLK,
  input  wire logic                          NRST,
  input  wire logic                          CE,
  input  wire logic                          SEC_TICK,
  input  wire logic                          FRAME_ERR,
  input  wire logic                          ALIGN_LOSS,
  input  wire logic                          FRAME_END,
  input  wire logic                          CRC_BIT_VALID,
  input  wire logic                          CRC_BIT,
  input  wire logic [3:0]                    CRC_RX,
  input  wire logic [lpm_pkg::IDX_W-1:0]     HIST_SEL,
  output logic                               UNAVAIL_STATE,
  output logic [lpm_pkg::TIMER_W-1:0]        INTERVAL_TIMER,
  output logic [lpm_pkg::CNT_W-1:0]          CUR_ERRORED_SECOND,
  output logic [lpm_pkg::CNT_W-1:0]          CUR_UNAVAILABLE_SECOND,
  output logic [lpm_pkg::CNT_W-1:0]          CUR_SEVERE_ERROR_SECOND,
  output logic [lpm_pkg::BBE_W-1:0]          CUR_BACKGROUND_BLOCK_ERROR,
  output logic [lpm_pkg::DAY_W-1:0]          DAY_ERRORED_SECOND,
  output logic [lpm_pkg::DAY_W-1:0]          DAY_UNAVAILABLE_SECOND,
  output logic [lpm_pkg::DAY_W-1:0]          DAY_SEVERE_ERROR_SECOND,
  output logic [lpm_pkg::DBBE_W-1:0]         DAY_BACKGROUND_BLOCK_ERROR,
  output logic [lpm_pkg::IDX_W-1:0]          VALID_INTERVALS,
  output logic [lpm_pkg::STAMP_W-1:0]        HIST_START,
  output logic [lpm_pkg::CNT_W-1:0]          HIST_ERRORED_SECOND,
  output logic [lpm_pkg::CNT_W-1:0]          HIST_UNAVAILABLE_SECOND,
  output logic [lpm_pkg::CNT_W-1:0]          HIST_SEVERE_ERROR_SECOND,
  output logic [lpm_pkg::BBE_W-1:0]          HIST_BACKGROUND_BLOCK_ERROR,
  output logic                               CRC_MISMATCH
);
  import lpm_pkg::*;

  // ----------------------------------------------------------------------
  // CRC-4 recompute over the frame
  // ----------------------------------------------------------------------
  logic [3:0] crc_q;
  logic [3:0] crc_d;
  logic [3:0] crc_step;
  logic       fb;
  logic       crc_bad;

  // Serial LFSR, MSB first; frame end reloads zero for the next frame
  // A frame with no valid bits compares zero against the check bits
  assign fb       = crc_q[3] ^ CRC_BIT;
  assign crc_step = {crc_q[2:0], 1'b0} ^ (fb ? CRC4_POLY : 4'h0);
  assign crc_d    = CRC_BIT_VALID ? crc_step : crc_q;
  assign crc_bad  = FRAME_END && (crc_d != CRC_RX); // R11

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      crc_q        <= 4'h0;
      CRC_MISMATCH <= 1'b0;
    end else if (CE) begin
      crc_q        <= FRAME_END ? 4'h0 : crc_d;
      CRC_MISMATCH <= crc_bad; // R11
    end
  end

  // ----------------------------------------------------------------------
  // Per-second event counts
  // ----------------------------------------------------------------------
  logic [EVT_W-1:0] crc_cnt_q;
  logic [EVT_W-1:0] loss_cnt_q;
  logic [EVT_W-1:0] fe_cnt_q;
  logic [EVT_W-1:0] crc_now;
  logic [EVT_W-1:0] loss_now;
  logic [EVT_W-1:0] fe_now;

  // Include the strobe cycle's own event so nothing is lost at the seam
  assign crc_now  = crc_cnt_q + EVT_W'(crc_bad);
  assign loss_now = loss_cnt_q + EVT_W'(ALIGN_LOSS);
  assign fe_now   = fe_cnt_q + EVT_W'(FRAME_ERR);

  // Saturating counters; a second cannot overflow them meaningfully
  // CE low holds the partial second, and events in those cycles are lost
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      crc_cnt_q  <= '0;
      loss_cnt_q <= '0;
      fe_cnt_q   <= '0;
    end else if (CE) begin
      crc_cnt_q  <= SEC_TICK ? '0 : (&crc_cnt_q ? crc_cnt_q : crc_now);
      loss_cnt_q <= SEC_TICK ? '0 : (&loss_cnt_q ? loss_cnt_q : loss_now);
      fe_cnt_q   <= SEC_TICK ? '0 : (&fe_cnt_q ? fe_cnt_q : fe_now);
    end
  end

  // ----------------------------------------------------------------------
  // Second classification
  // ----------------------------------------------------------------------
  logic es_sec;
  logic ses_sec;
  logic uas_sec;
  logic run_full;
  logic [RUN_W-1:0] run_q;
  logic             unavail_q;
  logic [EVT_W-1:0] blk_errs;

  assign es_sec   = (fe_now != '0) || (crc_now != '0); // R4
  // Sum of both kinds reaches the limit; framer aligns them to the tick R13
  assign ses_sec  = ({1'b0, crc_now} + {1'b0, loss_now})
                    >= {1'b0, SES_LIM_V}; // R5
  assign run_full = ses_sec && (run_q == UAS_RUN_V - RUN_W'(1));
  // The tenth severe second itself is the first one counted; the
  // non-severe second that ends the state is not, so the count never rises while
  // the state reads low
  assign uas_sec  = ses_sec && (unavail_q || run_full); // R1 R6
  assign blk_errs = ses_sec ? '0 : crc_now; // R7

  // Unavailable state is held from onset; any non-severe second ends it
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      run_q     <= '0;
      unavail_q <= 1'b0;
    end else if (CE && SEC_TICK) begin
      run_q     <= ses_sec ? (run_full ? run_q : run_q + RUN_W'(1)) : '0;
      unavail_q <= ses_sec ? (unavail_q || run_full) : 1'b0; // R6
    end
  end

  assign UNAVAIL_STATE = unavail_q; // R1

  // ----------------------------------------------------------------------
  // Interval counters
  // ----------------------------------------------------------------------
  logic iv_end;
  logic [TIMER_W-1:0] tmr_q;
  logic [CNT_W-1:0]   es_q;
  logic [CNT_W-1:0]   uas_q;
  logic [CNT_W-1:0]   ses_q;
  logic [BBE_W-1:0]   bbe_q;
  logic [CNT_W-1:0]   es_fin;
  logic [CNT_W-1:0]   uas_fin;
  logic [CNT_W-1:0]   ses_fin;
  logic [BBE_W-1:0]   bbe_fin;

  assign iv_end  = SEC_TICK && (tmr_q == TIMER_LAST); // R2
  // Totals including the second that closes now
  assign es_fin  = es_q + CNT_W'(es_sec);
  assign uas_fin = uas_q + CNT_W'(uas_sec);
  assign ses_fin = ses_q + CNT_W'(ses_sec);
  assign bbe_fin = bbe_q + BBE_W'(blk_errs);

  // Current-interval counters restart at the boundary
  // Sized for 900 seconds, so no count can wrap inside one interval
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tmr_q <= '0;
      es_q  <= '0;
      uas_q <= '0;
      ses_q <= '0;
      bbe_q <= '0;
    end else if (CE && SEC_TICK) begin
      tmr_q <= iv_end ? '0 : tmr_q + TIMER_W'(1); // R3 R12
      es_q  <= iv_end ? '0 : es_fin;  // R4 R12
      uas_q <= iv_end ? '0 : uas_fin; // R6
      ses_q <= iv_end ? '0 : ses_fin; // R5
      bbe_q <= iv_end ? '0 : bbe_fin; // R7
    end
  end

  assign INTERVAL_TIMER             = tmr_q; // R3
  assign CUR_ERRORED_SECOND         = es_q;
  assign CUR_UNAVAILABLE_SECOND     = uas_q;
  assign CUR_SEVERE_ERROR_SECOND    = ses_q;
  assign CUR_BACKGROUND_BLOCK_ERROR = bbe_q;

  // ----------------------------------------------------------------------
  // History ring of completed intervals
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0]   h_es  [HIST_DEPTH];
  logic [CNT_W-1:0]   h_uas [HIST_DEPTH];
  logic [CNT_W-1:0]   h_ses [HIST_DEPTH];
  logic [BBE_W-1:0]   h_bbe [HIST_DEPTH];
  logic [STAMP_W-1:0] h_st  [HIST_DEPTH];
  logic [IDX_W-1:0]   wr_q;
  logic [IDX_W-1:0]   nvalid_q;
  logic [STAMP_W-1:0] start_q;
  logic [IDX_W-1:0]   rd_idx;
  logic [IDX_W:0]     rd_sum;
  logic [STAMP_W:0]   st_sum;
  logic [STAMP_W-1:0] start_nx;

  // Newest record is HIST_SEL 0; ring index walks back from writer
  assign rd_sum = {1'b0, wr_q} + {1'b0, HIST_LAST} - {1'b0, HIST_SEL};
  assign rd_idx = (rd_sum >= {1'b0, HIST_FULL}) ?
                  IDX_W'(rd_sum - {1'b0, HIST_FULL}) : IDX_W'(rd_sum);
  // Start time is seconds since reset, wrapped at one day
  // One step is far below a day, so a single subtraction always wraps it
  assign st_sum   = {1'b0, start_q} + {1'b0, STAMP_STEP};
  assign start_nx = (st_sum > {1'b0, DAY_SECS_M1}) ?
                    STAMP_W'(st_sum - {1'b0, DAY_SECS_M1} - 18'h1) :
                    STAMP_W'(st_sum);

  // Memory array carries no reset; valid count guards stale slots
  // Eviction starts only once every slot has been written at least once
  always_ff @(posedge CLK) begin
    if (CE && SEC_TICK && iv_end) begin
      h_es[wr_q]  <= es_fin; // R10 R12
      h_uas[wr_q] <= uas_fin;
      h_ses[wr_q] <= ses_fin;
      h_bbe[wr_q] <= bbe_fin;
      h_st[wr_q]  <= start_q; // R10
    end
  end

  // Writer wraps over the oldest slot once 96 are held
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_q     <= '0;
      nvalid_q <= '0;
      start_q  <= '0;
    end else if (CE && SEC_TICK && iv_end) begin
      wr_q     <= (wr_q == HIST_LAST) ? '0 : wr_q + IDX_W'(1); // R12
      nvalid_q <= (nvalid_q == HIST_FULL) ? nvalid_q
                                          : nvalid_q + IDX_W'(1); // R9
      start_q  <= start_nx;
    end
  end

  assign VALID_INTERVALS = nvalid_q; // R9

  // Readout registered; unfilled slots read as zero
  // One cycle of latency from a select change to the outputs
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      HIST_START                  <= '0;
      HIST_ERRORED_SECOND         <= '0;
      HIST_UNAVAILABLE_SECOND     <= '0;
      HIST_SEVERE_ERROR_SECOND    <= '0;
      HIST_BACKGROUND_BLOCK_ERROR <= '0;
    end else if (CE) begin
      if (HIST_SEL < nvalid_q) begin
        HIST_START                  <= h_st[rd_idx];
        HIST_ERRORED_SECOND         <= h_es[rd_idx];
        HIST_UNAVAILABLE_SECOND     <= h_uas[rd_idx];
        HIST_SEVERE_ERROR_SECOND    <= h_ses[rd_idx];
        HIST_BACKGROUND_BLOCK_ERROR <= h_bbe[rd_idx];
      end else begin
        HIST_START                  <= '0;
        HIST_ERRORED_SECOND         <= '0;
        HIST_UNAVAILABLE_SECOND     <= '0;
        HIST_SEVERE_ERROR_SECOND    <= '0;
        HIST_BACKGROUND_BLOCK_ERROR <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // 24-hour totals
  // ----------------------------------------------------------------------
  logic [DAY_W-1:0]  d_es_q;
  logic [DAY_W-1:0]  d_uas_q;
  logic [DAY_W-1:0]  d_ses_q;
  logic [DBBE_W-1:0] d_bbe_q;
  logic              evict;
  logic [CNT_W-1:0]  ev_es;
  logic [CNT_W-1:0]  ev_uas;
  logic [CNT_W-1:0]  ev_ses;
  logic [BBE_W-1:0]  ev_bbe;

  // Sum of held records: add the new one, drop the one overwritten
  // Widths hold 96 full intervals, so the sliding sum cannot wrap
  assign evict  = (nvalid_q == HIST_FULL);
  assign ev_es  = evict ? h_es[wr_q]  : '0;
  assign ev_uas = evict ? h_uas[wr_q] : '0;
  assign ev_ses = evict ? h_ses[wr_q] : '0;
  assign ev_bbe = evict ? h_bbe[wr_q] : '0;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      d_es_q  <= '0;
      d_uas_q <= '0;
      d_ses_q <= '0;
      d_bbe_q <= '0;
    end else if (CE && SEC_TICK && iv_end) begin
      d_es_q  <= d_es_q + DAY_W'(es_fin) - DAY_W'(ev_es); // R8
      d_uas_q <= d_uas_q + DAY_W'(uas_fin) - DAY_W'(ev_uas);
      d_ses_q <= d_ses_q + DAY_W'(ses_fin) - DAY_W'(ev_ses);
      d_bbe_q <= d_bbe_q + DBBE_W'(bbe_fin) - DBBE_W'(ev_bbe); // R8
    end
  end

  assign DAY_ERRORED_SECOND         = d_es_q;
  assign DAY_UNAVAILABLE_SECOND     = d_uas_q;
  assign DAY_SEVERE_ERROR_SECOND    = d_ses_q;
  assign DAY_BACKGROUND_BLOCK_ERROR = d_bbe_q;

endmodule

// File: verification/lpm_monitor_sva.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker for the performance monitor
// ----------------------------------------
module lpm_monitor_sva
  import lpm_pkg::*;
(
  input wire logic               CLK,
  input wire logic               NRST,
  input wire logic               CE,
  input wire logic               SEC_TICK,
  input wire logic               FRAME_END,
  input wire logic               UNAVAIL_STATE,
  input wire logic [TIMER_W-1:0] INTERVAL_TIMER,
  input wire logic [CNT_W-1:0]   CUR_ERRORED_SECOND,
  input wire logic [CNT_W-1:0]   CUR_UNAVAILABLE_SECOND,
  input wire logic [CNT_W-1:0]   CUR_SEVERE_ERROR_SECOND,
  input wire logic [IDX_W-1:0]   VALID_INTERVALS,
  input wire logic               CRC_MISMATCH
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // A taken second, and the second that closes the interval
  sequence s_tick;
    CE && SEC_TICK;
  endsequence
  sequence s_close;
    s_tick ##0 INTERVAL_TIMER == TIMER_LAST;
  endsequence
  property p_step;
    s_tick ##0 INTERVAL_TIMER != TIMER_LAST |=>
      INTERVAL_TIMER == $past(INTERVAL_TIMER) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("timer step");
  property p_hold;
    !(CE && SEC_TICK) |=> $stable(INTERVAL_TIMER);
  endproperty
  a_hold: assert property (p_hold) else $error("timer moved");
  property p_close;
    s_close |=> INTERVAL_TIMER == '0 && CUR_ERRORED_SECOND == '0
      && CUR_SEVERE_ERROR_SECOND == '0;
  endproperty
  a_close: assert property (p_close) else $error("no restart");
  property p_valid;
    s_close ##0 VALID_INTERVALS != HIST_FULL |=>
      VALID_INTERVALS == $past(VALID_INTERVALS) + 1'b1;
  endproperty
  a_valid: assert property (p_valid) else $error("valid count");
  property p_cnt;
    !(CE && SEC_TICK) |=> $stable(CUR_SEVERE_ERROR_SECOND)
      && $stable(CUR_UNAVAILABLE_SECOND) && $stable(VALID_INTERVALS);
  endproperty
  a_cnt: assert property (p_cnt) else $error("count moved");
  property p_uas;
    $changed(CUR_UNAVAILABLE_SECOND) && CUR_UNAVAILABLE_SECOND != '0
      |-> UNAVAIL_STATE;
  endproperty
  a_uas: assert property (p_uas) else $error("state low");
  property p_fall;
    $fell(UNAVAIL_STATE) |-> $past(SEC_TICK)
      && (INTERVAL_TIMER == '0 || $stable(CUR_UNAVAILABLE_SECOND));
  endproperty
  a_fall: assert property (p_fall) else $error("state fell");
  property p_rise;
    $rose(UNAVAIL_STATE) |-> $past(SEC_TICK);
  endproperty
  a_rise: assert property (p_rise) else $error("state rose");
  property p_crc;
    CRC_MISMATCH |-> $past(FRAME_END);
  endproperty
  a_crc: assert property (p_crc) else $error("stray crc");
endmodule

bind lpm_monitor lpm_monitor_sva u_lpm_monitor_sva (
  .CLK(CLK), .NRST(NRST), .CE(CE), .SEC_TICK(SEC_TICK),
  .FRAME_END(FRAME_END), .UNAVAIL_STATE(UNAVAIL_STATE),
  .INTERVAL_TIMER(INTERVAL_TIMER),
  .CUR_ERRORED_SECOND(CUR_ERRORED_SECOND),
  .CUR_UNAVAILABLE_SECOND(CUR_UNAVAILABLE_SECOND),
  .CUR_SEVERE_ERROR_SECOND(CUR_SEVERE_ERROR_SECOND),
  .VALID_INTERVALS(VALID_INTERVALS), .CRC_MISMATCH(CRC_MISMATCH));

// File: verification/lpm_framer_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Receive framer stand-in, falling edges
// ----------------------------------------
module lpm_framer_model (
  input  wire logic CLK,
  output logic      FRAME_ERR,
  output logic      ALIGN_LOSS,
  output logic      FRAME_END,
  output logic      CRC_BIT_VALID,
  output logic      CRC_BIT,
  output logic [3:0] CRC_RX
);
  logic [3:0] crc_q;
  initial begin
    {FRAME_ERR, ALIGN_LOSS, FRAME_END, CRC_BIT_VALID, CRC_BIT} = '0;
    CRC_RX = 4'ha;
  end
  // Pulses kept apart by an idle cycle so none merge
  task automatic pulses(input int n_al, input int n_fe);
    for (int i = 0; i < n_al || i < n_fe; i++) begin
      ALIGN_LOSS = i < n_al;
      FRAME_ERR  = i < n_fe;
      @(negedge CLK);
      {ALIGN_LOSS, FRAME_ERR} = 2'b00;
      @(negedge CLK);
    end
  endtask
  // Eight bits MSB first; a bad frame flips one check bit
  task automatic frame(input bit bad);
    crc_q = 4'h0;
    for (int i = 0; i < 8; i++) begin
      CRC_BIT_VALID = 1'b1;
      CRC_BIT = 1'($urandom_range(1));
      crc_q = {crc_q[2:0], 1'b0} ^ ((crc_q[3] ^ CRC_BIT) ? 4'h3 : 4'h0);
      @(negedge CLK);
    end
    CRC_BIT_VALID = 1'b0;
    CRC_BIT = ~CRC_BIT;
    FRAME_END = 1'b1;
    CRC_RX = crc_q ^ {3'h0, bad};
    @(negedge CLK);
    FRAME_END = 1'b0;
    CRC_RX = ~CRC_RX; // Stale check bits never look valid
  endtask
endmodule

// File: verification/lpm_monitor_tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module lpm_monitor_tb;
  import lpm_pkg::*;
  logic               clk, nrst, ce, sec_tick, fr_err, al_loss, fr_end;
  logic               crc_vld, crc_bit, unavail, crc_mis;
  logic [3:0]         crc_rx;
  logic [IDX_W-1:0]   hist_sel, valid_n;
  logic [TIMER_W-1:0] timer;
  logic [CNT_W-1:0]   c_es, c_uas, c_ses, h_es, h_uas, h_ses;
  logic [BBE_W-1:0]   c_bbe, h_bbe;
  logic [DAY_W-1:0]   d_es, d_uas, d_ses;
  logic [DBBE_W-1:0]  d_bbe;
  logic [STAMP_W-1:0] h_start;
  int                 n_mismatch, compares, cycles, n_bad, n_seen;
  int                 e_tmr, e_es, e_uas, e_ses, e_bbe, e_run;
  lpm_monitor u_lpm_monitor (.CLK(clk), .NRST(nrst), .CE(ce),
    .SEC_TICK(sec_tick), .FRAME_ERR(fr_err), .ALIGN_LOSS(al_loss),
    .FRAME_END(fr_end), .CRC_BIT_VALID(crc_vld), .CRC_BIT(crc_bit),
    .CRC_RX(crc_rx), .HIST_SEL(hist_sel), .UNAVAIL_STATE(unavail),
    .INTERVAL_TIMER(timer), .CUR_ERRORED_SECOND(c_es),
    .CUR_UNAVAILABLE_SECOND(c_uas), .CUR_SEVERE_ERROR_SECOND(c_ses),
    .CUR_BACKGROUND_BLOCK_ERROR(c_bbe), .DAY_ERRORED_SECOND(d_es),
    .DAY_UNAVAILABLE_SECOND(d_uas), .DAY_SEVERE_ERROR_SECOND(d_ses),
    .DAY_BACKGROUND_BLOCK_ERROR(d_bbe), .VALID_INTERVALS(valid_n),
    .HIST_START(h_start), .HIST_ERRORED_SECOND(h_es),
    .HIST_UNAVAILABLE_SECOND(h_uas), .HIST_SEVERE_ERROR_SECOND(h_ses),
    .HIST_BACKGROUND_BLOCK_ERROR(h_bbe), .CRC_MISMATCH(crc_mis));
  lpm_framer_model u_lpm_framer_model (.CLK(clk), .FRAME_ERR(fr_err),
    .ALIGN_LOSS(al_loss), .FRAME_END(fr_end), .CRC_BIT_VALID(crc_vld),
    .CRC_BIT(crc_bit), .CRC_RX(crc_rx));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard well above the roughly 11k cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      final_report();
    end
  end
  // Pulse counted mid-cycle, clear of the edge that launches it
  always @(negedge clk) begin
    if (crc_mis === 1'b1) n_seen++;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic bit severe(int crc, int al);
    return crc + al >= SES_LIMIT;
  endfunction
  task automatic tick();
    sec_tick = 1'b1;
    @(negedge clk);
    sec_tick = 1'b0;
    @(negedge clk);
  endtask
  // One second of traffic, one good frame always, then its tick
  task automatic sec(input int al, fe, bad);
    bit sv;
    u_lpm_framer_model.pulses(al, fe);
    for (int i = 0; i <= bad; i++) u_lpm_framer_model.frame(i < bad);
    n_bad += bad;
    sv = severe(bad, al);
    tick();
    e_run = sv ? e_run + 1 : 0;
    e_es += (fe > 0 || bad > 0);
    e_ses += sv;
    e_uas += (e_run >= UAS_RUN);
    e_bbe += sv ? 0 : bad;
    e_tmr++;
    check("unavail", unavail, e_run >= UAS_RUN);
    check("timer", timer, e_tmr);
    check("es", c_es, e_es);
    check("ses", c_ses, e_ses);
    check("uas", c_uas, e_uas);
    check("bbe", c_bbe, e_bbe);
  endtask
  initial begin
    {nrst, ce, sec_tick, hist_sel} = '0;
    void'($urandom(49535));
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    ce = 1'b1;
    repeat (20) sec($urandom_range(3), $urandom_range(2), $urandom_range(2));
    sec(299, 0, 0); // Just short of severe, alignment alone not errored
    sec(150, 1, 150); // Sum reaches the limit, blocks not background
    repeat (11) sec(300, 0, 0);
    sec(0, 0, 1);
    ce = 1'b0;
    tick();
    check("frozen", timer, e_tmr);
    ce = 1'b1;
    repeat (900 - e_tmr) tick();
    check("wrap", timer, 0);
    check("cleared", c_ses, 0);
    check("valid", valid_n, 1);
    check("d_es", d_es, e_es);
    check("d_uas", d_uas, e_uas);
    check("d_ses", d_ses, e_ses);
    check("d_bbe", d_bbe, e_bbe);
    check("h_uas", h_uas, e_uas);
    check("h_bbe", h_bbe, e_bbe);
    check("h_es", h_es, e_es);
    check("h_ses", h_ses, e_ses);
    check("h_start", h_start, 0);
    hist_sel = 7'h01;
    repeat (2) @(negedge clk);
    check("h_empty", h_ses, 0);
    check("crc", n_seen, n_bad);
    final_report();
  end
endmodule
